// ==== core/bbr_params.svh ====
// constants for the bit-band alias remapper
// Operation
// - bit-band regions sit in lowest 64 KB of SRAM and lowest 1 MB of peripheral space, each with alias.
// - direct SRAM bit-band accesses 0x2000.0000-0x2000.FFFF behave as ordinary SRAM accesses.
// - data accesses to SRAM alias 0x2200.0000-0x221F.FFFF go to the bit-band location.
// - instruction fetches to the SRAM alias range are passed on unremapped.
// - direct peripheral bit-band accesses 0x4000.0000-0x400F.FFFF behave as ordinary peripheral accesses.
// - peripheral alias data accesses remap; fetches there are refused with an error.
// - alias write becomes read of the location, single-bit update, then write back.
// - alias offset equals byte offset times 32 plus bit number times 4.
// - alias address bits select one of eight bits, 0 to 7, in the byte.
// - underlying access keeps the alias access size: word, halfword or byte.
// - written bit 0 sets or clears the targeted bit-band bit.
// - written data bits 31 down to 1 are ignored.
// - alias read returns 0x0000.0000 or 0x0000.0001 from the targeted bit.
// - little-endian lanes: byte offset selects the data lane that is modified.
`ifndef BBR_PARAMS_SVH
`define BBR_PARAMS_SVH

// region bounds
`define BBR_SRAM_BB_BASE  32'h2000_0000
`define BBR_SRAM_BB_END   32'h2000_FFFF
`define BBR_SRAM_AL_BASE  32'h2200_0000
`define BBR_SRAM_AL_END   32'h221F_FFFF
`define BBR_PER_BB_BASE   32'h4000_0000
`define BBR_PER_BB_END    32'h400F_FFFF
`define BBR_PER_AL_BASE   32'h4200_0000
`define BBR_PER_AL_END    32'h43FF_FFFF

// alias decode: offset = byte*32 + bit*4
`define BBR_BYTE_SHIFT    5
`define BBR_BIT_LSB       2
`define BBR_BIT_MSB       4
`define BBR_BYTE_OFS_W    20

// access size codes
`define BBR_SIZE_BYTE     2'h0
`define BBR_SIZE_HALF     2'h1
`define BBR_SIZE_WORD     2'h2

`endif

// ==== core/bbr_pkg.sv ====
// types for the bit-band alias remapper
package bbr_pkg;
  typedef enum logic [1:0] {
    BBR_IDLE   = 2'b00,
    BBR_PASS   = 2'b01,
    BBR_RMW_RD = 2'b10,
    BBR_RMW_WR = 2'b11
  } bbr_state_e;
endpackage

// ==== core/bbr_bit_lane.sv ====
// single-bit extract and merge on a little-endian data word
`timescale 1ns/1ns
module bbr_bit_lane (
  // word and bit position
  input  wire logic [31:0] word_in,
  input  wire logic [1:0]  lane,
  input  wire logic [2:0]  bit_sel,
  input  wire logic        set_val,
  // results
  output logic             bit_out,
  output logic [31:0]      merged
);
  logic [4:0] idx;

  // lane n carries byte address n, so lane*8 + bit is the word bit
  always_comb begin
    idx     = {lane, bit_sel};
    bit_out = word_in[idx];
    merged  = word_in;
    merged[idx] = set_val;
  end
endmodule

// ==== core/bbr_remapper.sv ====
// bit-band alias remapper between the data bus master and memory
`timescale 1ns/1ns
`include "bbr_params.svh"
module bbr_remapper (
  // clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RESET_N,
  // upstream request (one-cycle pulse, attributes valid with it)
  input  wire logic        UP_REQ,
  input  wire logic [31:0] UP_ADDR,
  input  wire logic [1:0]  UP_SIZE,
  input  wire logic        UP_WRITE,
  input  wire logic        UP_FETCH,
  input  wire logic [31:0] UP_WDATA,
  // upstream answer
  output logic             UP_DONE,
  output logic             UP_ERROR,
  output logic [31:0]      UP_RDATA,
  output logic             UP_BUSY,
  // downstream request
  output logic             DN_REQ,
  output logic [31:0]      DN_ADDR,
  output logic [1:0]       DN_SIZE,
  output logic             DN_WRITE,
  output logic [31:0]      DN_WDATA,
  output logic             DN_LOCK,
  // downstream answer
  input  wire logic        DN_DONE,
  input  wire logic        DN_ERROR,
  input  wire logic [31:0] DN_RDATA
);
  // address in [lo, hi]
  function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // bit-band address of an alias word, aligned down to the access size
  function automatic logic [31:0] bb_target(input logic [31:0] a, input logic [31:0] al_base,
                                            input logic [31:0] bb_base, input logic [1:0] size);
    logic [31:0] ofs;
    logic [31:0] t;
    ofs = a - al_base;
    t   = bb_base + {12'h000, ofs[`BBR_BYTE_OFS_W+`BBR_BYTE_SHIFT-1:`BBR_BYTE_SHIFT]};
    case (size)
      `BBR_SIZE_WORD: bb_target = {t[31:2], 2'h0};
      `BBR_SIZE_HALF: bb_target = {t[31:1], 1'h0};
      default:        bb_target = t;
    endcase
  endfunction

  bbr_pkg::bbr_state_e state;
  bbr_pkg::bbr_state_e next_state;
  logic        alias_rd;
  logic        next_alias_rd;
  logic [1:0]  lane;
  logic [1:0]  next_lane;
  logic [2:0]  bit_sel;
  logic [2:0]  next_bit_sel;
  logic        set_val;
  logic        next_set_val;
  logic        next_up_done;
  logic        next_up_error;
  logic [31:0] next_up_rdata;
  logic        next_up_busy;
  logic        next_dn_req;
  logic [31:0] next_dn_addr;
  logic [1:0]  next_dn_size;
  logic        next_dn_write;
  logic [31:0] next_dn_wdata;
  logic        next_dn_lock;
  logic        in_sram_al;
  logic        in_per_al;
  logic        bit_now;
  logic [31:0] merged_now;
  logic [31:0] al_target;

  // decode of the incoming address
  always_comb begin
    in_sram_al = in_range(UP_ADDR, `BBR_SRAM_AL_BASE, `BBR_SRAM_AL_END);
    in_per_al  = in_range(UP_ADDR, `BBR_PER_AL_BASE, `BBR_PER_AL_END);
    al_target  = in_per_al ? bb_target(UP_ADDR, `BBR_PER_AL_BASE, `BBR_PER_BB_BASE, UP_SIZE)
                           : bb_target(UP_ADDR, `BBR_SRAM_AL_BASE, `BBR_SRAM_BB_BASE, UP_SIZE);
  end

  // bit pick and merge on returned memory data
  bbr_bit_lane i_bbr_bit_lane (
    .word_in (DN_RDATA),
    .lane    (lane),
    .bit_sel (bit_sel),
    .set_val (set_val),
    .bit_out (bit_now),
    .merged  (merged_now)
  );

  // sequencer next values
  always_comb begin
    next_state    = state;
    next_alias_rd = alias_rd;
    next_lane     = lane;
    next_bit_sel  = bit_sel;
    next_set_val  = set_val;
    next_up_done  = 1'b0;
    next_up_error = UP_ERROR;
    next_up_rdata = UP_RDATA;
    next_up_busy  = UP_BUSY;
    next_dn_req   = 1'b0;
    next_dn_addr  = DN_ADDR;
    next_dn_size  = DN_SIZE;
    next_dn_write = DN_WRITE;
    next_dn_wdata = DN_WDATA;
    next_dn_lock  = DN_LOCK;
    case (state)
      bbr_pkg::BBR_IDLE: begin
        if (UP_REQ) begin
          if (in_per_al && UP_FETCH) begin
            // fetches from the peripheral alias never reach memory
            next_up_done  = 1'b1;
            next_up_error = 1'b1;
            next_up_rdata = 32'h0000_0000;
          end else if ((in_sram_al && !UP_FETCH) || in_per_al) begin
            next_dn_req   = 1'b1;
            next_dn_addr  = al_target;
            next_dn_size  = UP_SIZE;
            next_dn_write = 1'b0;
            next_dn_wdata = 32'h0000_0000;
            // lane from the unaligned byte offset; the aligned target would lose it for word and half
            next_lane     = UP_ADDR[`BBR_BYTE_SHIFT+1:`BBR_BYTE_SHIFT];
            next_bit_sel  = UP_ADDR[`BBR_BIT_MSB:`BBR_BIT_LSB];
            next_set_val  = UP_WDATA[0];
            next_alias_rd = !UP_WRITE;
            next_dn_lock  = UP_WRITE;
            next_up_busy  = 1'b1;
            next_state    = UP_WRITE ? bbr_pkg::BBR_RMW_RD : bbr_pkg::BBR_PASS;
          end else begin
            // plain traffic, sram alias fetches included
            next_dn_req   = 1'b1;
            next_dn_addr  = UP_ADDR;
            next_dn_size  = UP_SIZE;
            next_dn_write = UP_WRITE;
            next_dn_wdata = UP_WDATA;
            next_alias_rd = 1'b0;
            next_dn_lock  = 1'b0;
            next_up_busy  = 1'b1;
            next_state    = bbr_pkg::BBR_PASS;
          end
        end
      end
      bbr_pkg::BBR_PASS: begin
        if (DN_DONE) begin
          next_up_done  = 1'b1;
          next_up_error = DN_ERROR;
          next_up_rdata = alias_rd ? {31'h0000_0000, bit_now} : DN_RDATA;
          next_up_busy  = 1'b0;
          next_state    = bbr_pkg::BBR_IDLE;
        end
      end
      bbr_pkg::BBR_RMW_RD: begin
        if (DN_DONE && DN_ERROR) begin
          // failed read: no write back, lock dropped
          next_up_done  = 1'b1;
          next_up_error = 1'b1;
          next_up_rdata = 32'h0000_0000;
          next_up_busy  = 1'b0;
          next_dn_lock  = 1'b0;
          next_state    = bbr_pkg::BBR_IDLE;
        end else if (DN_DONE) begin
          // write issued next cycle, lock held so nothing slips in
          next_dn_req   = 1'b1;
          next_dn_write = 1'b1;
          next_dn_wdata = merged_now;
          next_state    = bbr_pkg::BBR_RMW_WR;
        end
      end
      bbr_pkg::BBR_RMW_WR: begin
        if (DN_DONE) begin
          next_up_done  = 1'b1;
          next_up_error = DN_ERROR;
          next_up_rdata = 32'h0000_0000;
          next_up_busy  = 1'b0;
          next_dn_lock  = 1'b0;
          next_state    = bbr_pkg::BBR_IDLE;
        end
      end
      default: next_state = bbr_pkg::BBR_IDLE;
    endcase
  end

  // register stage, every output comes from here
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state    <= bbr_pkg::BBR_IDLE;
      alias_rd <= 1'b0;
      lane     <= 2'h0;
      bit_sel  <= 3'h0;
      set_val  <= 1'b0;
      UP_DONE  <= 1'b0;
      UP_ERROR <= 1'b0;
      UP_RDATA <= 32'h0000_0000;
      UP_BUSY  <= 1'b0;
      DN_REQ   <= 1'b0;
      DN_ADDR  <= 32'h0000_0000;
      DN_SIZE  <= 2'h0;
      DN_WRITE <= 1'b0;
      DN_WDATA <= 32'h0000_0000;
      DN_LOCK  <= 1'b0;
    end else begin
      state    <= next_state;
      alias_rd <= next_alias_rd;
      lane     <= next_lane;
      bit_sel  <= next_bit_sel;
      set_val  <= next_set_val;
      UP_DONE  <= next_up_done;
      UP_ERROR <= next_up_error;
      UP_RDATA <= next_up_rdata;
      UP_BUSY  <= next_up_busy;
      DN_REQ   <= next_dn_req;
      DN_ADDR  <= next_dn_addr;
      DN_SIZE  <= next_dn_size;
      DN_WRITE <= next_dn_write;
      DN_WDATA <= next_dn_wdata;
      DN_LOCK  <= next_dn_lock;
    end
  end

  // checks on the sequencer
  property p_fetch_refused;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (state == bbr_pkg::BBR_IDLE && UP_REQ && UP_FETCH && in_per_al) |=> (UP_DONE && UP_ERROR && !DN_REQ);
  endproperty
  a_fetch_refused: assert property (p_fetch_refused) else $error("peripheral alias fetch not refused");

  property p_alias_addr;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (state == bbr_pkg::BBR_IDLE && UP_REQ && in_sram_al && !UP_FETCH)
      |=> (DN_REQ && !DN_WRITE && DN_ADDR == $past(al_target) && DN_SIZE == $past(UP_SIZE));
  endproperty
  a_alias_addr: assert property (p_alias_addr) else $error("sram alias access not remapped");

  property p_fetch_pass;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (state == bbr_pkg::BBR_IDLE && UP_REQ && in_sram_al && UP_FETCH) |=> (DN_REQ && DN_ADDR == $past(UP_ADDR));
  endproperty
  a_fetch_pass: assert property (p_fetch_pass) else $error("sram alias fetch was remapped");

  property p_pass_through;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (state == bbr_pkg::BBR_IDLE && UP_REQ && !in_sram_al && !in_per_al)
      |=> (DN_REQ && DN_ADDR == $past(UP_ADDR) && DN_SIZE == $past(UP_SIZE)
           && DN_WRITE == $past(UP_WRITE) && DN_WDATA == $past(UP_WDATA));
  endproperty
  a_pass_through: assert property (p_pass_through) else $error("plain access altered");

  property p_read_value;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (state == bbr_pkg::BBR_PASS && alias_rd && DN_DONE)
      |=> (UP_DONE && UP_RDATA[31:1] == 31'h0000_0000 && UP_RDATA[0] == $past(bit_now));
  endproperty
  a_read_value: assert property (p_read_value) else $error("alias read value wrong");

  property p_rmw_back;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (state == bbr_pkg::BBR_RMW_RD && DN_DONE && !DN_ERROR)
      |=> (DN_REQ && DN_WRITE && DN_LOCK && DN_ADDR == $past(DN_ADDR) && DN_SIZE == $past(DN_SIZE));
  endproperty
  a_rmw_back: assert property (p_rmw_back) else $error("write back not issued after read");

  property p_bit_merge;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (state == bbr_pkg::BBR_RMW_RD && DN_DONE && !DN_ERROR)
      |=> (DN_WDATA[{lane, bit_sel}] == set_val
           && (DN_WDATA ^ $past(DN_RDATA)) == (32'h0000_0001 << {lane, bit_sel}) * ($past(bit_now) ^ set_val));
  endproperty
  a_bit_merge: assert property (p_bit_merge) else $error("bit merge touched wrong bits");

  property p_lock_span;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (state == bbr_pkg::BBR_IDLE && UP_REQ && UP_WRITE && !UP_FETCH && (in_sram_al || in_per_al))
      |=> DN_LOCK throughout (state != bbr_pkg::BBR_IDLE)[*2];
  endproperty
  a_lock_span: assert property (p_lock_span) else $error("lock dropped inside update");

  // a refused fetch taken in the done cycle answers at once, so only a quiet done cycle must end
  property p_done_pulse;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (UP_DONE && !UP_REQ) |=> !UP_DONE;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");

  property p_per_remap;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (state == bbr_pkg::BBR_IDLE && UP_REQ && in_per_al && !UP_FETCH)
      |=> (DN_REQ && !DN_WRITE && DN_ADDR == $past(al_target) && DN_SIZE == $past(UP_SIZE)
           && DN_LOCK == $past(UP_WRITE));
  endproperty
  a_per_remap: assert property (p_per_remap) else $error("peripheral alias access not remapped");
endmodule

// ==== tb/bbr_mem_model.sv ====
// downstream memory model answering the remapper's requests
`timescale 1ns/1ns
module bbr_mem_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // request from the remapper
  input  wire logic        req,
  input  wire logic [31:0] addr,
  input  wire logic [1:0]  size,
  input  wire logic        write,
  input  wire logic [31:0] wdata,
  // bench knobs: answer delay and error on every answered access
  input  wire logic [3:0]  dly,
  input  wire logic        err_en,
  // answer
  output logic             done,
  output logic             error,
  output logic [31:0]      rdata
);
  logic [31:0] mem [logic [29:0]];
  logic [3:0]  cnt;
  logic [31:0] a_q;
  logic [31:0] w_q;
  logic [31:0] cur;
  logic [1:0]  s_q;
  logic        wr_q;

  // byte lanes touched by an access, little-endian
  function automatic logic [31:0] lanes(input logic [1:0] s, input logic [1:0] o);
    if (s == 2'h2)
      return 32'hFFFF_FFFF;
    if (s == 2'h1)
      return 32'h0000_FFFF << (o[1] * 16);
    return 32'h0000_00FF << (o * 8);
  endfunction

  // answer at least one cycle late; rdata scrambles when not valid
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt   <= 4'h0;
      done  <= 1'h0;
      error <= 1'h0;
      rdata <= 32'h0;
    end else begin
      done  <= 1'h0;
      error <= 1'h0;
      rdata <= ~rdata;
      if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
        if (cnt == 4'h1) begin
          cur = mem.exists(a_q[31:2]) ? mem[a_q[31:2]] : 32'h0;
          done  <= 1'h1;
          error <= err_en;
          rdata <= cur;
          // a refused access leaves memory untouched
          if (wr_q && !err_en)
            mem[a_q[31:2]] = (cur & ~lanes(s_q, a_q[1:0])) | (w_q & lanes(s_q, a_q[1:0]));
        end
      end else if (req) begin
        cnt  <= (dly == 4'h0) ? 4'h1 : dly;
        a_q  <= addr;
        s_q  <= size;
        wr_q <= write;
        w_q  <= wdata;
      end
    end
  end
endmodule

// ==== tb/bbr_remapper_test.sv ====
// self-checking bench for the bit-band alias remapper
`timescale 1ns/1ns
module bbr_remapper_test;
  logic        SYS_CLK, RESET_N, UP_REQ, UP_WRITE, UP_FETCH, UP_DONE, UP_ERROR, UP_BUSY;
  logic        DN_REQ, DN_WRITE, DN_LOCK, DN_DONE, DN_ERROR, err_en, dn_lock, er, bz;
  logic [31:0] UP_ADDR, UP_WDATA, UP_RDATA, DN_ADDR, DN_WDATA, DN_RDATA, dn_addr, dn_wdata, rd;
  logic [1:0]  UP_SIZE, DN_SIZE, dn_size;
  logic [3:0]  dly;
  int          miscompares, tests_run, dn_cnt, b;

  bbr_remapper i_bbr_remapper (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .UP_REQ(UP_REQ), .UP_ADDR(UP_ADDR),
    .UP_SIZE(UP_SIZE), .UP_WRITE(UP_WRITE), .UP_FETCH(UP_FETCH), .UP_WDATA(UP_WDATA), .UP_DONE(UP_DONE),
    .UP_ERROR(UP_ERROR), .UP_RDATA(UP_RDATA), .UP_BUSY(UP_BUSY), .DN_REQ(DN_REQ), .DN_ADDR(DN_ADDR),
    .DN_SIZE(DN_SIZE), .DN_WRITE(DN_WRITE), .DN_WDATA(DN_WDATA), .DN_LOCK(DN_LOCK), .DN_DONE(DN_DONE),
    .DN_ERROR(DN_ERROR), .DN_RDATA(DN_RDATA));
  bbr_mem_model i_bbr_mem_model (.clk(SYS_CLK), .rst_n(RESET_N), .req(DN_REQ), .addr(DN_ADDR),
    .size(DN_SIZE), .write(DN_WRITE), .wdata(DN_WDATA), .dly(dly), .err_en(err_en), .done(DN_DONE),
    .error(DN_ERROR), .rdata(DN_RDATA));

  initial begin
    SYS_CLK = 1'h0;
    forever #2 SYS_CLK = ~SYS_CLK;
  end

  // record each downstream request; dn_lock notes whether lock held on all of them
  always @(posedge SYS_CLK) begin
    if (DN_REQ === 1'h1) begin
      dn_cnt++;
      dn_addr  = DN_ADDR;
      dn_size  = DN_SIZE;
      dn_wdata = DN_WDATA;
      dn_lock  = dn_lock & DN_LOCK;
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic give_verdict();
    if (miscompares == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  function automatic logic [31:0] mem_at(input logic [31:0] a);
    return i_bbr_mem_model.mem[a[31:2]];
  endfunction

  // one access, entered at a falling edge; next one may follow in the done cycle
  task automatic acc(input logic [31:0] a, input logic [1:0] s, input logic w, input logic f, input logic [31:0] d);
    int n;
    dn_cnt   = 0;
    dn_lock  = 1'h1;
    UP_REQ   = 1'h1;
    UP_ADDR  = a;
    UP_SIZE  = s;
    UP_WRITE = w;
    UP_FETCH = f;
    UP_WDATA = d;
    @(negedge SYS_CLK);
    UP_REQ = 1'h0;
    bz     = UP_BUSY;
    for (n = 0; n < 40 && UP_DONE !== 1'h1; n++)
      @(negedge SYS_CLK);
    if (n == 40) begin
      miscompares++;
      give_verdict();
    end
    rd = UP_RDATA;
    er = UP_ERROR;
  endtask

  task automatic t_plain();
    i_bbr_mem_model.mem[30'h1000_0001] = 32'hBEEF_0000;
    acc(32'h2000_0010, 2'h2, 1'h1, 1'h0, 32'hCAFE_F00D);
    chk("pass addr", 32'h2000_0010, dn_addr);
    chk("pass data", 32'hCAFE_F00D, dn_wdata);
    chk("pass busy", 32'h1, {31'h0, bz});
    chk("pass busy end", 32'h0, {31'h0, UP_BUSY});
    acc(32'h2000_0010, 2'h2, 1'h0, 1'h0, 32'h0);
    chk("pass read", 32'hCAFE_F00D, rd);
    acc(32'h4000_0006, 2'h1, 1'h0, 1'h0, 32'h0);
    chk("periph read", 32'hBEEF_0000, rd);
    chk("periph size", 32'h1, {30'h0, dn_size});
    chk("periph lock", 32'h0, {31'h0, dn_lock});
  endtask

  task automatic t_alias_rd();
    i_bbr_mem_model.mem[30'h0800_0041] = 32'h00A5_0000;
    i_bbr_mem_model.mem[30'h0800_3FFF] = 32'h8000_0000;
    for (b = 0; b < 8; b++) begin
      acc(32'h2200_0000 + 32'h106 * 32 + b * 4, 2'h0, 1'h0, 1'h0, 32'h0);
      chk("alias bit", 32'(8'hA5 >> b) & 32'h1, rd);
      chk("alias target", 32'h2000_0106, dn_addr);
    end
    acc(32'h221F_FFFC, 2'h2, 1'h0, 1'h0, 32'h0);
    chk("alias end", 32'h1, rd);
    chk("alias end addr", 32'h2000_FFFC, dn_addr);
  endtask

  task automatic t_alias_wr();
    dly = 4'h3;
    i_bbr_mem_model.mem[30'h1000_0008] = 32'h1234_5678;
    acc(32'h4200_0424, 2'h0, 1'h1, 1'h0, 32'hFFFF_FFFE);
    chk("rmw count", 32'h2, dn_cnt);
    chk("rmw byte addr", 32'h4000_0021, dn_addr);
    chk("rmw lock", 32'h1, {31'h0, dn_lock});
    chk("rmw clear", 32'h1234_5478, mem_at(32'h4000_0020));
    acc(32'h4200_046C, 2'h2, 1'h1, 1'h0, 32'hFFFF_FFFF);
    chk("rmw word size", 32'h2, {30'h0, dn_size});
    chk("rmw write rdata", 32'h0, rd);
    chk("rmw set", 32'h1A34_5478, mem_at(32'h4000_0020));
    acc(32'h4200_0440, 2'h1, 1'h1, 1'h0, 32'h0000_0001);
    chk("rmw half addr", 32'h4000_0022, dn_addr);
    chk("rmw half", 32'h1A35_5478, mem_at(32'h4000_0020));
    dly = 4'h1;
  endtask

  task automatic t_fetch_err();
    acc(32'h2200_0000, 2'h2, 1'h0, 1'h1, 32'h0);
    chk("sram fetch addr", 32'h2200_0000, dn_addr);
    acc(32'h4200_0000, 2'h2, 1'h0, 1'h1, 32'h0);
    chk("periph fetch err", 32'h1, {31'h0, er});
    chk("periph fetch req", 32'h0, dn_cnt);
    chk("periph fetch busy", 32'h0, {31'h0, bz});
    @(negedge SYS_CLK);
    err_en = 1'h1;
    acc(32'h4200_0424, 2'h0, 1'h1, 1'h0, 32'h1);
    chk("read err", 32'h1, {31'h0, er});
    chk("read err reqs", 32'h1, dn_cnt);
    chk("read err mem", 32'h1A35_5478, mem_at(32'h4000_0020));
    err_en = 1'h0;
  endtask

  initial begin
    RESET_N     = 1'h0;
    UP_REQ      = 1'h0;
    UP_ADDR     = 32'h0;
    UP_SIZE     = 2'h0;
    UP_WRITE    = 1'h0;
    UP_FETCH    = 1'h0;
    UP_WDATA    = 32'h0;
    dly         = 4'h1;
    err_en      = 1'h0;
    miscompares = 0;
    tests_run   = 0;
    dn_cnt      = 0;
    repeat (3) @(negedge SYS_CLK);
    RESET_N = 1'h1;
    chk("reset idle", 32'h0, {28'h0, UP_DONE, UP_BUSY, DN_REQ, DN_LOCK});
    t_plain();
    t_alias_rd();
    t_alias_wr();
    t_fetch_err();
    give_verdict();
  end
endmodule
